// File: hw/tmr_pkg.sv
package tmr_pkg;
  // Register byte offsets
  localparam logic [7:0]  RUN_CTRL_OFS   = 8'h00;  // Run control register
  localparam logic [7:0]  CLK_CFG_OFS    = 8'h04;  // Clock generator configuration
  localparam logic [7:0]  CAP_ZERO_OFS   = 8'h08;  // Capture value zero
  localparam logic [7:0]  CAP_ONE_OFS    = 8'h0C;  // Capture value one
  localparam logic [7:0]  PRE_STAT_OFS   = 8'h10;  // Prescaler count readback
  // Field positions
  localparam int          RUN_BIT_POS    = 0;      // Prescaler run bit
  localparam int          PRCK_LSB       = 0;      // Prescaler clock select [2:0]
  localparam int          GEAR_LSB       = 4;      // Gear code [6:4]
  localparam int          FPSEL_POS      = 8;      // Peripheral clock select
  // Reset values
  localparam logic [31:0] RUN_RST        = 32'h0000_0000;
  localparam logic [31:0] CFG_RST        = 32'h0000_0000;
  // Clock select codes
  localparam logic [2:0]  GEAR_FULL      = 3'h0;   // fc
  localparam logic [2:0]  GEAR_HALF      = 3'h4;   // fc/2
  localparam logic [2:0]  GEAR_QUARTER   = 3'h5;   // fc/4
  localparam logic [2:0]  PRCK_MAX       = 3'h5;   // fperiph/32
  localparam logic [2:0]  PRCK_FS        = 3'h7;   // Low-speed clock fs
  // Prescaler taps: divide by 2, 8 and 32
  localparam int          TAP_DIV2_BIT   = 0;
  localparam int          TAP_DIV8_BIT   = 2;
  localparam int          TAP_DIV32_BIT  = 4;
  // Clock configuration carried together
  typedef struct packed {
    logic       fpsel;  // 0 gear clock, 1 undivided clock
    logic [2:0] gear;   // Gear code
    logic [2:0] prck;   // Prescaler clock select
  } clk_cfg_t;
  // Tick bundle to the up-counter
  typedef struct packed {
    logic div2;
    logic div8;
    logic div32;
  } tap_t;
endpackage : tmr_pkg

// File: hw/cap_store.sv
`timescale 1ns/1ps
// Two capture words with registered read port
module cap_store #(
  parameter int W = 16
) (
  input  wire logic         core_clk_i,
  input  wire logic         we0_i,       // Load word zero
  input  wire logic         we1_i,       // Load word one
  input  wire logic [W-1:0] wdata_i,     // Up-counter value
  input  wire logic         rsel_i,      // Read select
  output logic      [W-1:0] rdata_o      // Registered read data
);
  logic [W-1:0] mem_r [2];   // Contents undefined after reset
  logic [W-1:0] mem_nxt [2];
  logic [W-1:0] rd_nxt;
  // Next contents and read word
  always_comb begin
    mem_nxt[0] = we0_i ? wdata_i : mem_r[0];
    mem_nxt[1] = we1_i ? wdata_i : mem_r[1];
    rd_nxt     = mem_r[rsel_i];
  end
  // Storage, no reset
  always_ff @(posedge core_clk_i) begin
    mem_r[0] <= mem_nxt[0];
    mem_r[1] <= mem_nxt[1];
    rdata_o  <= rd_nxt;
  end
endmodule : cap_store

// File: hw/timer_prescaler_and_capture.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// RQ1: Captures read 16 bits, upper zero, read-only
// RQ2: Four-bit prescaler feeds up-counter source clock
// RQ3: Three-bit code selects periph divide or fs
// RQ4: One bit picks gear clock or fc
// RQ5: Gear code passes, halves or quarters fc
// RQ6: Run one counts; zero clears and stops
// RQ7: Taps give input divided 2, 8, 32
// RQ8: Every channel behaves identically
// RQ9: Capture contents undefined after reset; upper zero
// RQ10: Capture loads counter, holds until next event
module timer_prescaler_and_capture #(
  parameter int CW = 16   // Capture width
) (
  input  wire logic          core_clk_i,
  input  wire logic          rstn_i,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          fs_tick_i,   // Low-speed clock tick
  input  wire logic [CW-1:0] channel_up_counter_i,
  input  wire logic          cap0_evt_i,  // Capture event zero
  input  wire logic          cap1_evt_i,  // Capture event one
  output tmr_pkg::tap_t      taps_o       // One-cycle tick per tap
);
  // Software state
  logic                  run_r, run_nxt;         // prescaler_run_bit
  tmr_pkg::clk_cfg_t     cfg_r, cfg_nxt;         // clockgen_system_config
  // Clock chain state
  logic [1:0]            gear_cnt_r, gear_cnt_nxt;  // Gear divider phase
  logic [4:0]            per_cnt_r, per_cnt_nxt;    // Peripheral divide phase
  logic [3:0]            pre_r, pre_nxt;         // Prescaler counter
  logic                  wrap_r, wrap_nxt;       // Phase past the prescaler wrap
  logic [4:0]            ext_cnt;                // Prescaler with wrap phase on top
  tmr_pkg::tap_t         taps_nxt;               // Tick pulses before the register
  // Bus state
  logic [31:0]           prdata_nxt;             // Next read data register
  logic [31:0]           reg_word;               // Read value of a plain register
  logic                  pready_nxt;             // Answer after first access cycle
  logic                  pslverr_nxt;            // Refusal flag with the answer
  logic                  hit_cap0;               // Address hits capture zero
  logic                  hit_cap1;               // Address hits capture one
  logic                  rd_cap;                 // Address hits either capture
  logic [CW-1:0]         cap_rd;                 // Registered capture word
  // Clock chain ticks
  logic                  gear_tick;              // Gear clock tick
  logic                  periph_tick;            // Peripheral clock tick
  logic                  pre_in;                 // Prescaler input clock tick
  // Bus phases
  logic                  setup;                  // APB setup cycle
  logic                  access;                 // APB access cycle
  logic                  hit;                    // Address is mapped
  logic                  wr_ok;                  // Write completes this edge

  // Transfer phases
  assign setup  = psel && !penable;
  assign access = psel && penable;

  // Register writes and run control
  always_comb begin
    run_nxt = run_r;
    cfg_nxt = cfg_r;
    // Writes land at the edge that completes the transfer
    wr_ok   = access && pready && pwrite;
    // RQ6 run bit write
    if (wr_ok && paddr == tmr_pkg::RUN_CTRL_OFS) begin
      run_nxt = pwdata[tmr_pkg::RUN_BIT_POS];
    end
    // RQ3 RQ4 RQ5 clock selection write
    if (wr_ok && paddr == tmr_pkg::CLK_CFG_OFS) begin
      cfg_nxt.prck  = pwdata[tmr_pkg::PRCK_LSB+:3];
      cfg_nxt.gear  = pwdata[tmr_pkg::GEAR_LSB+:3];
      cfg_nxt.fpsel = pwdata[tmr_pkg::FPSEL_POS];
    end
  end

  // RQ8 shared per channel
  // Clock chain: gear, peripheral divide, prescaler
  // Dividers run free; only the prescaler obeys the run bit
  always_comb begin
    gear_cnt_nxt = gear_cnt_r + 2'h1;
    // RQ5 gear divide
    unique case (cfg_r.gear)
      tmr_pkg::GEAR_HALF:    gear_tick = gear_cnt_r[0];
      tmr_pkg::GEAR_QUARTER: gear_tick = &gear_cnt_r;
      default:               gear_tick = 1'b1;
    endcase
    // RQ4 peripheral source
    periph_tick = cfg_r.fpsel ? 1'b1 : gear_tick;
    per_cnt_nxt = periph_tick ? per_cnt_r + 5'h01 : per_cnt_r;
    // RQ3 prescaler input select
    if (cfg_r.prck == tmr_pkg::PRCK_FS) begin
      pre_in = fs_tick_i;
    end else if (cfg_r.prck > tmr_pkg::PRCK_MAX) begin
      pre_in = 1'b0;                     // Reserved code gives no clock
    end else if (cfg_r.prck == 3'h0) begin
      pre_in = periph_tick;
    end else begin
      pre_in = periph_tick && (&(per_cnt_r | ~((5'h01 << cfg_r.prck) - 5'h01)) == 1'b1)
               && ((per_cnt_r & ((5'h01 << cfg_r.prck) - 5'h01)) == ((5'h01 << cfg_r.prck) - 5'h01));
    end
    // RQ6 run clears and stops
    // RQ2 four-bit prescaler
    pre_nxt = !run_r ? 4'h0 : (pre_in ? pre_r + 4'h1 : pre_r);
    // RQ7 slowest tap counts every other wrap
    wrap_nxt = !run_r ? 1'b0 : ((pre_in && (&pre_r)) ? !wrap_r : wrap_r);
    ext_cnt  = {wrap_r, pre_r};
    // RQ7 taps on carry of bits 0, 2, 4
    taps_nxt.div2  = run_r && pre_in && (&ext_cnt[tmr_pkg::TAP_DIV2_BIT:0]);
    taps_nxt.div8  = run_r && pre_in && (&ext_cnt[tmr_pkg::TAP_DIV8_BIT:0]);
    taps_nxt.div32 = run_r && pre_in && (&ext_cnt[tmr_pkg::TAP_DIV32_BIT:0]);
  end

  // RQ10 capture store, RQ9 no reset on contents
  cap_store #(.W(CW)) u_cap (
    .core_clk_i (core_clk_i),
    .we0_i      (cap0_evt_i),
    .we1_i      (cap1_evt_i),
    .wdata_i    (channel_up_counter_i),
    .rsel_i     (hit_cap1),
    .rdata_o    (cap_rd)
  );

  // APB decode: one wait state, read data comes from a register
  always_comb begin
    hit_cap0    = paddr == tmr_pkg::CAP_ZERO_OFS;
    hit_cap1    = paddr == tmr_pkg::CAP_ONE_OFS;
    rd_cap      = hit_cap0 || hit_cap1;
    hit         = rd_cap || paddr == tmr_pkg::RUN_CTRL_OFS
                  || paddr == tmr_pkg::CLK_CFG_OFS || paddr == tmr_pkg::PRE_STAT_OFS;
    // Ready for one cycle, raised after the first access cycle
    pready_nxt  = access && !pready;
    // RQ1 read-only captures refuse writes
    pslverr_nxt = access && !pready && (!hit || (pwrite && (rd_cap
                  || paddr == tmr_pkg::PRE_STAT_OFS)));
    // Plain register read values
    unique case (paddr)
      tmr_pkg::RUN_CTRL_OFS: reg_word = {31'h0, run_r};
      tmr_pkg::CLK_CFG_OFS:  reg_word = {23'h0, cfg_r.fpsel, 1'h0, cfg_r.gear, 1'h0, cfg_r.prck};
      tmr_pkg::PRE_STAT_OFS: reg_word = {28'h0, pre_r};
      default:               reg_word = 32'h0;   // Captures and holes
    endcase
    // Read data held between transfers
    prdata_nxt  = prdata;
    if (access && !pready) begin
      // RQ1 upper half reads zero
      prdata_nxt = rd_cap ? 32'(cap_rd) : reg_word;
    end
  end

  // State registers, reset to idle
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_r      <= tmr_pkg::RUN_RST[tmr_pkg::RUN_BIT_POS];
      cfg_r      <= '0;
      gear_cnt_r <= 2'h0;
      per_cnt_r  <= 5'h00;
      pre_r      <= 4'h0;
      wrap_r     <= 1'b0;
      taps_o     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0;
    end else begin
      run_r      <= run_nxt;
      cfg_r      <= cfg_nxt;
      gear_cnt_r <= gear_cnt_nxt;
      per_cnt_r  <= per_cnt_nxt;
      pre_r      <= pre_nxt;
      wrap_r     <= wrap_nxt;
      taps_o     <= taps_nxt;
      pready     <= pready_nxt;
      pslverr    <= pslverr_nxt;
      prdata     <= prdata_nxt;
    end
  end

  // Assertions
  // Capture event on zero, a quiet cycle, then a read of zero
  sequence cap_then_read_s;
    cap0_evt_i && !cap1_evt_i ##1 !cap0_evt_i && !cap1_evt_i
    ##1 !cap0_evt_i && !cap1_evt_i && setup && hit_cap0;
  endsequence
  // Two steady cycles at half gear rate, undivided prescaler input
  sequence half_gear_steady_s;
    !cfg_r.fpsel && cfg_r.gear == tmr_pkg::GEAR_HALF && cfg_r.prck == 3'h0
    && run_r && run_nxt && cfg_nxt == cfg_r ##1 run_nxt && cfg_nxt == cfg_r;
  endsequence
  // Stopped prescaler reads zero next cycle
  a_stop_clears: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ6
    !run_r |=> pre_r == 4'h0) else $error("prescaler not cleared");
  // Slow taps only fire with the faster ones
  a_tap_div32: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ7
    taps_o.div32 |-> taps_o.div8 && taps_o.div2) else $error("tap nesting broken");
  // Capture answers carry zero upper half
  a_cap_upper: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ1
    pready && rd_cap |-> prdata[31:16] == 16'h0) else $error("capture upper not zero");
  // Stored word is the counter at the event
  a_cap_load: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ10
    cap_then_read_s |=> cap_rd == $past(channel_up_counter_i, 3))
    else $error("capture mismatch");
  // No div2 tick while stopped
  a_stopped_ticks: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ2
    !run_r |=> !taps_o.div2) else $error("tick while stopped");
  // Undivided clock steps the prescaler every cycle
  a_fpsel_full: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ4
    cfg_r.fpsel && cfg_r.prck == 3'h0 && run_r && run_nxt |=> pre_r == $past(pre_r) + 4'h1)
    else $error("undivided input missed");
  // Writes to capture zero are refused with the answer
  a_ro_refused: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ1
    access && !pready && pwrite && hit_cap0 |=> pslverr && pready)
    else $error("write not refused");
  // Half gear rate steps once in two cycles
  a_gear_half: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ5
    half_gear_steady_s |=> pre_r == $past(pre_r, 2) + 4'h1)
    else $error("gear half rate wrong");
  // Low-speed input holds the count between ticks
  a_fs_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ3
    cfg_r.prck == tmr_pkg::PRCK_FS && run_r && !fs_tick_i |=> pre_r == $past(pre_r))
    else $error("count moved without tick");
  // Counting restarts from zero after a start
  a_start_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)  // RQ6
    !run_r ##1 run_r |-> pre_r == 4'h0) else $error("start not from zero");
endmodule : timer_prescaler_and_capture

// File: tb/timer_prescaler_and_capture_bench.sv
`timescale 1ns/1ps
// Compare one value, count and report
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module timer_prescaler_and_capture_bench;
  logic          core_clk_i, rstn_i, psel, penable, pwrite, pready, pslverr;
  logic          cap0_evt_i, cap1_evt_i, err;
  logic          fs_tick_i = 1'b0;                // Low-speed tick, free running
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd, seed;
  logic [15:0]   channel_up_counter_i, cnt_v;
  tmr_pkg::tap_t taps_o;
  logic [15:0]   cap_m [2];                       // Capture model
  int            fails, checks_done, n2, n8, n32;
  int            fs_cnt = 0;                      // Low-speed tick divider
  // Clock selection table and expected input divide
  int            fp_t [10] = '{1, 1, 1, 1, 1, 1, 0, 0, 0, 1};
  int            ge_t [10] = '{0, 0, 0, 0, 0, 0, 4, 5, 0, 0};
  int            pr_t [10] = '{0, 1, 2, 3, 4, 5, 0, 0, 1, 7};
  int            dv_t [10] = '{1, 2, 4, 8, 16, 32, 2, 4, 2, 4};

  timer_prescaler_and_capture u_dut (.core_clk_i, .rstn_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fs_tick_i, .channel_up_counter_i,
    .cap0_evt_i, .cap1_evt_i, .taps_o);

  // Core clock, 40 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // Low-speed tick every fourth cycle
  always @(posedge core_clk_i) begin
    fs_cnt <= (fs_cnt + 1) % 4;
    fs_tick_i <= (fs_cnt == 3);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Verdict and end of run
  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk_i);
      if (pready === 1'b1) break;
      if (i == 15) begin
        fails++;
        close_out();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Count tap pulses over n cycles
  task automatic taps(input int n);
    n2 = 0;
    n8 = 0;
    n32 = 0;
    repeat (n) begin
      @(posedge core_clk_i);
      n2 += (taps_o.div2 === 1'b1);
      n8 += (taps_o.div8 === 1'b1);
      n32 += (taps_o.div32 === 1'b1);
    end
  endtask : taps

  // Capture a random counter value, then move the counter away
  task automatic cap(input int k);
    seed = lfsr(seed);
    cnt_v = seed[15:0];
    @(posedge core_clk_i);
    channel_up_counter_i <= cnt_v;
    if (k == 0) cap0_evt_i <= 1'b1;
    else cap1_evt_i <= 1'b1;
    @(posedge core_clk_i);
    cap0_evt_i <= 1'b0;
    cap1_evt_i <= 1'b0;
    channel_up_counter_i <= ~cnt_v;
    cap_m[k] = cnt_v;
  endtask : cap

  // Main sequence
  initial begin
    {rstn_i, psel, penable, pwrite, paddr, pwdata} = '0;
    {cap0_evt_i, cap1_evt_i, channel_up_counter_i} = '0;
    seed = 32'h524D1469;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, tmr_pkg::RUN_CTRL_OFS, 32'h0);
    `CHK(rd, tmr_pkg::RUN_RST)
    apb(1'b0, tmr_pkg::CLK_CFG_OFS, 32'h0);
    `CHK(rd, tmr_pkg::CFG_RST)
    for (int k = 0; k < 4; k++) begin
      cap(k % 2);
      apb(1'b0, (k % 2) ? tmr_pkg::CAP_ONE_OFS : tmr_pkg::CAP_ZERO_OFS, 32'h0);
      `CHK(rd, {16'h0000, cap_m[k % 2]})
      `CHK(err, 1'b0)
    end
    apb(1'b0, tmr_pkg::CAP_ZERO_OFS, 32'h0);
    `CHK(rd, {16'h0000, cap_m[0]})
    apb(1'b1, tmr_pkg::CAP_ZERO_OFS, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    apb(1'b0, tmr_pkg::CAP_ZERO_OFS, 32'h0);
    `CHK(rd, {16'h0000, cap_m[0]})
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1)
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, tmr_pkg::RUN_CTRL_OFS, 32'h0);
      apb(1'b1, tmr_pkg::CLK_CFG_OFS, (fp_t[i] << tmr_pkg::FPSEL_POS) |
          (ge_t[i] << tmr_pkg::GEAR_LSB) | pr_t[i]);
      apb(1'b1, tmr_pkg::RUN_CTRL_OFS, 32'h1);
      taps(256);
      taps(1024);
      `CHK(n2, 1024 / (2 * dv_t[i]))
      `CHK(n8, 1024 / (8 * dv_t[i]))
      `CHK(n32, 1024 / (32 * dv_t[i]))
    end
    apb(1'b1, tmr_pkg::RUN_CTRL_OFS, 32'h0);
    taps(256);
    `CHK(n2 + n8 + n32, 0)
    apb(1'b0, tmr_pkg::PRE_STAT_OFS, 32'h0);
    `CHK(rd, 32'h0)
    close_out();
  end
endmodule : timer_prescaler_and_capture_bench
